//--- rtl/rtc_twi_map.svh
`ifndef RTC_TWI_MAP_SVH
`define RTC_TWI_MAP_SVH

// Seven-bit target address; with the direction bit the byte reads D0h or D1h.
`define TWI_TARGET_ADDR   7'h68
`define TWI_DIR_READ      1'b1
// Register pointer is six bits wide, so upper address bits are ignored.
`define TWI_PTR_W         6
`define TWI_MEM_DEPTH     64
`define TWI_PTR_RESET     6'h00
`define TWI_PTR_STEP      6'h01
`define TWI_BITS_PER_BYTE 4'h8
`define TWI_LAST_TX_BIT   3'h7
`define TWI_BYTE_RESET    8'h00
`define TWI_CNT_RESET     4'h0
`define TWI_TXCNT_RESET   3'h0
`define TWI_TXCNT_STEP    3'h1
`define TWI_CNT_STEP      4'h1
`define TWI_SYNC_IDLE     2'h3
`define TWI_XSYNC_IDLE    3'h0
// Address byte fields: target address above, direction flag in bit zero.
`define TWI_ADDR_HI       7
`define TWI_ADDR_LO       1
`define TWI_DIR_BIT       0
// Positions of the three words that cross into the reference clock domain.
`define TWI_XS_WR         2
`define TWI_XS_NACK       1
`define TWI_XS_BUSY       0

`endif

//--- rtl/rtc_twi_pkg.sv
package rtc_twi_pkg;

   typedef enum logic [5:0] {
      ST_IDLE      = 6'h01,
      ST_RX        = 6'h02,
      ST_RX_ACK    = 6'h04,
      ST_TX        = 6'h08,
      ST_TX_ACK    = 6'h10,
      ST_WAIT_STOP = 6'h20
   } link_state_t;

   typedef enum logic [1:0] {
      PH_TARGET = 2'h0,
      PH_PTR    = 2'h1,
      PH_DATA   = 2'h2
   } byte_phase_t;

endpackage

//--- rtl/sync_2ff.sv
`timescale 1ns/10ps
`default_nettype none

module sync_2ff #(
   parameter int         WIDTH = 1,
   parameter logic [WIDTH-1:0] INIT = '0
) (
   input  wire logic             i_clk,
   input  wire logic             i_reset,
   input  wire logic [WIDTH-1:0] i_async,
   output logic      [WIDTH-1:0] o_sync
);

   logic [WIDTH-1:0] meta_reg;

   // Two flops in series; the first is read only by the second.
   always_ff @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         meta_reg <= INIT;
         o_sync   <= INIT;
      end else begin
         meta_reg <= i_async;
         o_sync   <= meta_reg;
      end
   end

endmodule // sync_2ff

`default_nettype wire

//--- rtl/rtc_two_wire_target_port.sv
`timescale 1ns/10ps
`default_nettype none

`include "rtc_twi_map.svh"

// Function
// - SDA falling while SCL high starts transfer
// - SDA rising while SCL high stops transfer
// - Repeated start accepted without prior stop
// - Transfers are eight-bit bytes after start
// - Unlimited bytes between start and stop
// - Register address increments after every data byte
// - Change SDA on SCL low, sample high
// - SDA change during SCL high is condition
// - Receiver acknowledges each byte, active low
// - Acknowledge driven after eighth falling edge
// - Missing acknowledge means failed transfer
// - Release SDA at ninth falling edge
// - After read NACK, release and await stop
// - Respond only to own target address
// - Seven-bit address, D1h read, D0h write
// - Lines stay high when bus idle
// - Only lower six address bits decoded
module rtc_two_wire_target_port
   import rtc_twi_pkg::*;
(
   input  wire logic        i_ref_clk,
   input  wire logic        i_reset,
   input  wire logic        i_link_clk,
   input  wire logic        i_scl,
   input  wire logic        i_sda_in,
   output logic             o_sda_out,
   output logic             o_sda_oe,
   output logic             o_wr_strobe,
   output logic [5:0]       o_wr_addr,
   output logic [7:0]       o_wr_data,
   output logic             o_busy,
   output logic             o_nack_seen
);

   // Link-domain state, the register store and the words that cross domains.
   logic [1:0]                line_sync;
   logic                      scl_s;
   logic                      sda_s;
   logic                      scl_p_reg;
   logic                      sda_p_reg;
   logic                      start_det;
   logic                      stop_det;
   logic                      scl_rise;
   logic                      scl_fall;
   link_state_t               state_reg;
   byte_phase_t               phase_reg;
   logic [3:0]                rx_cnt_reg;
   logic [2:0]                tx_cnt_reg;
   logic [7:0]                shift_reg;
   logic                      read_reg;
   logic                      master_ack_reg;
   logic [`TWI_PTR_W-1:0]     ptr_reg;
   logic [7:0]                mem [0:`TWI_MEM_DEPTH-1];
   logic [7:0]                rd_byte;
   logic                      wr_toggle_reg;
   logic [5:0]                wr_addr_hold_reg;
   logic [7:0]                wr_data_hold_reg;
   logic                      busy_link_reg;
   logic                      nack_toggle_reg;
   logic [2:0]                ref_sync;
   logic                      wr_toggle_p_reg;
   logic                      nack_toggle_p_reg;

   // Both bus lines pass two flops in the link domain before use.
   sync_2ff #(
      .WIDTH (2),
      .INIT  (`TWI_SYNC_IDLE)
   ) u_line_sync (
      .i_clk   (i_link_clk),
      .i_reset (i_reset),
      .i_async ({i_scl, i_sda_in}),
      .o_sync  (line_sync)
   );

   // The upper bit of the synchronised pair is the clock line, the lower the data line.
   assign scl_s = line_sync[1];
   assign sda_s = line_sync[0];

   // Previous line levels start at the idle high level, so reset makes no false edge.
   always_ff @(posedge i_link_clk or posedge i_reset) begin
      if (i_reset) begin
         scl_p_reg <= 1'b1;
         sda_p_reg <= 1'b1;
      end else begin
         scl_p_reg <= scl_s;
         sda_p_reg <= sda_s;
      end
   end

   // Conditions and clock edges come from the synchronised lines only.
   assign start_det = scl_s & scl_p_reg & sda_p_reg & ~sda_s;
   assign stop_det  = scl_s & scl_p_reg & ~sda_p_reg & sda_s;
   assign scl_rise  = scl_s & ~scl_p_reg;
   assign scl_fall  = ~scl_s & scl_p_reg;
   assign rd_byte   = mem[ptr_reg];

   // Register store written by the controller, one byte per acknowledged data byte.
   always_ff @(posedge i_link_clk) begin
      if (state_reg == ST_RX && scl_fall && rx_cnt_reg == `TWI_BITS_PER_BYTE && phase_reg == PH_DATA) begin
         mem[ptr_reg] <= shift_reg;
      end
   end

   // Target state machine on the link clock.
   always_ff @(posedge i_link_clk or posedge i_reset) begin
      if (i_reset) begin
         state_reg        <= ST_IDLE;
         phase_reg        <= PH_TARGET;
         rx_cnt_reg       <= `TWI_CNT_RESET;
         tx_cnt_reg       <= `TWI_TXCNT_RESET;
         shift_reg        <= `TWI_BYTE_RESET;
         read_reg         <= 1'b0;
         master_ack_reg   <= 1'b0;
         ptr_reg          <= `TWI_PTR_RESET;
         o_sda_oe         <= 1'b0;
         wr_toggle_reg    <= 1'b0;
         wr_addr_hold_reg <= `TWI_PTR_RESET;
         wr_data_hold_reg <= `TWI_BYTE_RESET;
         nack_toggle_reg  <= 1'b0;
      end else if (start_det) begin
         state_reg  <= ST_RX;
         phase_reg  <= PH_TARGET;
         rx_cnt_reg <= `TWI_CNT_RESET;
         o_sda_oe   <= 1'b0;
      end else if (stop_det) begin
         state_reg <= ST_IDLE;
         o_sda_oe  <= 1'b0;
      end else begin
         case (state_reg)
            ST_RX: begin
               if (scl_rise && rx_cnt_reg != `TWI_BITS_PER_BYTE) begin
                  shift_reg  <= {shift_reg[6:0], sda_s};
                  rx_cnt_reg <= rx_cnt_reg + `TWI_CNT_STEP;
               end else if (scl_fall && rx_cnt_reg == `TWI_BITS_PER_BYTE) begin
                  case (phase_reg)
                     PH_TARGET: begin
                        if (shift_reg[`TWI_ADDR_HI:`TWI_ADDR_LO] == `TWI_TARGET_ADDR) begin
                           read_reg  <= (shift_reg[`TWI_DIR_BIT] == `TWI_DIR_READ);
                           phase_reg <= PH_PTR;
                           o_sda_oe  <= 1'b1;
                           state_reg <= ST_RX_ACK;
                        end else begin
                           state_reg <= ST_WAIT_STOP;
                        end
                     end
                     PH_PTR: begin
                        ptr_reg   <= shift_reg[`TWI_PTR_W-1:0];
                        phase_reg <= PH_DATA;
                        o_sda_oe  <= 1'b1;
                        state_reg <= ST_RX_ACK;
                     end
                     default: begin
                        ptr_reg          <= ptr_reg + `TWI_PTR_STEP;
                        wr_addr_hold_reg <= ptr_reg;
                        wr_data_hold_reg <= shift_reg;
                        wr_toggle_reg    <= ~wr_toggle_reg;
                        o_sda_oe         <= 1'b1;
                        state_reg        <= ST_RX_ACK;
                     end
                  endcase
               end
            end
            ST_RX_ACK: begin
               if (scl_fall) begin
                  if (read_reg) begin
                     shift_reg  <= rd_byte;
                     ptr_reg    <= ptr_reg + `TWI_PTR_STEP;
                     tx_cnt_reg <= `TWI_TXCNT_RESET;
                     o_sda_oe   <= ~rd_byte[7];
                     state_reg  <= ST_TX;
                  end else begin
                     o_sda_oe   <= 1'b0;
                     rx_cnt_reg <= `TWI_CNT_RESET;
                     state_reg  <= ST_RX;
                  end
               end
            end
            ST_TX: begin
               if (scl_fall) begin
                  if (tx_cnt_reg == `TWI_LAST_TX_BIT) begin
                     o_sda_oe  <= 1'b0;
                     state_reg <= ST_TX_ACK;
                  end else begin
                     shift_reg  <= {shift_reg[6:0], 1'b0};
                     o_sda_oe   <= ~shift_reg[6];
                     tx_cnt_reg <= tx_cnt_reg + `TWI_TXCNT_STEP;
                  end
               end
            end
            ST_TX_ACK: begin
               if (scl_rise) begin
                  master_ack_reg <= ~sda_s;
               end else if (scl_fall) begin
                  if (master_ack_reg) begin
                     shift_reg  <= rd_byte;
                     ptr_reg    <= ptr_reg + `TWI_PTR_STEP;
                     tx_cnt_reg <= `TWI_TXCNT_RESET;
                     o_sda_oe   <= ~rd_byte[7];
                     state_reg  <= ST_TX;
                  end else begin
                     nack_toggle_reg <= ~nack_toggle_reg;
                     state_reg       <= ST_WAIT_STOP;
                  end
               end
            end
            ST_WAIT_STOP: begin
               o_sda_oe <= 1'b0;
            end
            ST_IDLE: begin
               o_sda_oe <= 1'b0;
            end
            default: begin
               state_reg <= ST_IDLE;
               o_sda_oe  <= 1'b0;
            end
         endcase
      end
   end

   // Open-drain data pin only ever pulls low.
   always_ff @(posedge i_link_clk or posedge i_reset) begin
      if (i_reset) begin
         o_sda_out <= 1'h0;
      end else begin
         o_sda_out <= 1'h0;
      end
   end

   // Busy level on the link side, sent across as a level.
   always_ff @(posedge i_link_clk or posedge i_reset) begin
      if (i_reset) begin
         busy_link_reg <= 1'h0;
      end else begin
         busy_link_reg <= (state_reg != ST_IDLE);
      end
   end

   // Write and read-end events cross as toggles; busy crosses as a level.
   sync_2ff #(
      .WIDTH (3),
      .INIT  (`TWI_XSYNC_IDLE)
   ) u_ref_sync (
      .i_clk   (i_ref_clk),
      .i_reset (i_reset),
      .i_async ({wr_toggle_reg, nack_toggle_reg, busy_link_reg}),
      .o_sync  (ref_sync)
   );

   // A change of the write toggle becomes a one-cycle strobe.
   always_ff @(posedge i_ref_clk or posedge i_reset) begin
      if (i_reset) begin
         wr_toggle_p_reg <= 1'h0;
         o_wr_strobe     <= 1'h0;
      end else begin
         wr_toggle_p_reg <= ref_sync[`TWI_XS_WR];
         o_wr_strobe     <= ref_sync[`TWI_XS_WR] ^ wr_toggle_p_reg;
      end
   end

   // Held write words are stable for a whole byte time when the toggle arrives.
   always_ff @(posedge i_ref_clk or posedge i_reset) begin
      if (i_reset) begin
         o_wr_addr <= `TWI_PTR_RESET;
         o_wr_data <= `TWI_BYTE_RESET;
      end else if (ref_sync[`TWI_XS_WR] ^ wr_toggle_p_reg) begin
         o_wr_addr <= wr_addr_hold_reg;
         o_wr_data <= wr_data_hold_reg;
      end
   end

   // A change of the read-end toggle becomes a one-cycle pulse.
   always_ff @(posedge i_ref_clk or posedge i_reset) begin
      if (i_reset) begin
         nack_toggle_p_reg <= 1'h0;
         o_nack_seen       <= 1'h0;
      end else begin
         nack_toggle_p_reg <= ref_sync[`TWI_XS_NACK];
         o_nack_seen       <= ref_sync[`TWI_XS_NACK] ^ nack_toggle_p_reg;
      end
   end

   // Busy crosses as a level and needs no edge logic.
   always_ff @(posedge i_ref_clk or posedge i_reset) begin
      if (i_reset) begin
         o_busy <= 1'h0;
      end else begin
         o_busy <= ref_sync[`TWI_XS_BUSY];
      end
   end

endmodule // rtc_two_wire_target_port

`default_nettype wire

//--- tb/twi_asserts.sv
`timescale 1ns/10ps
`default_nettype none
module twi_asserts (
   input wire logic       i_ref_clk,
   input wire logic       i_reset,
   input wire logic       i_link_clk,
   input wire logic       i_scl,
   input wire logic       i_sda_in,
   input wire logic       o_sda_out,
   input wire logic       o_sda_oe,
   input wire logic       o_wr_strobe,
   input wire logic [5:0] o_wr_addr,
   input wire logic [7:0] o_wr_data,
   input wire logic       o_busy,
   input wire logic       o_nack_seen
);
   logic       seen_reg;
   logic [5:0] last_reg;
   always_ff @(posedge i_ref_clk or posedge i_reset) begin
      if (i_reset) seen_reg <= 1'b0;
      else if (o_wr_strobe) seen_reg <= 1'b1;
      else if (!o_busy) seen_reg <= 1'b0;
   end
   always_ff @(posedge i_ref_clk) begin
      if (o_wr_strobe) last_reg <= o_wr_addr;
   end
   a_strobe_pulse: assert property (@(posedge i_ref_clk) disable iff (i_reset) o_wr_strobe |=> !o_wr_strobe)
      else $error("strobe too long");
   a_addr_step: assert property (@(posedge i_ref_clk) disable iff (i_reset)
      o_wr_strobe && seen_reg |-> o_wr_addr == last_reg + 6'h01) else $error("address did not step");
   a_data_stand: assert property (@(posedge i_ref_clk) disable iff (i_reset)
      o_wr_strobe |=> $stable(o_wr_addr) && $stable(o_wr_data)) else $error("write data moved");
   a_strobe_busy: assert property (@(posedge i_ref_clk) disable iff (i_reset) o_wr_strobe |-> o_busy)
      else $error("strobe outside transfer");
   a_nack_pulse: assert property (@(posedge i_ref_clk) disable iff (i_reset)
      o_nack_seen |-> o_busy ##1 !o_nack_seen) else $error("bad nack pulse");
   a_oe_low: assert property (@(posedge i_link_clk) disable iff (i_reset)
      $changed(o_sda_oe) |-> !i_scl && !$past(i_scl, 2)) else $error("data moved with clock high");
   a_oe_stands: assert property (@(posedge i_link_clk) disable iff (i_reset)
      $rose(o_sda_oe) |=> o_sda_oe [*8]) else $error("drive dropped early");
   a_open_drain: assert property (@(posedge i_link_clk) disable iff (i_reset) o_sda_oe |-> !o_sda_out)
      else $error("line driven high");
   c_write: cover property (@(posedge i_ref_clk) o_wr_strobe);
   c_nack: cover property (@(posedge i_ref_clk) o_nack_seen);
   c_drive: cover property (@(posedge i_link_clk) $rose(o_sda_oe));
endmodule // twi_asserts
bind rtc_two_wire_target_port twi_asserts twi_asserts_inst (.i_ref_clk(i_ref_clk), .i_reset(i_reset),
   .i_link_clk(i_link_clk), .i_scl(i_scl), .i_sda_in(i_sda_in), .o_sda_out(o_sda_out), .o_sda_oe(o_sda_oe),
   .o_wr_strobe(o_wr_strobe), .o_wr_addr(o_wr_addr), .o_wr_data(o_wr_data), .o_busy(o_busy),
   .o_nack_seen(o_nack_seen));
`default_nettype wire

//--- tb/twi_host.sv
`timescale 1ns/10ps
`default_nettype none
module twi_host (
   input  wire logic i_link_clk,
   input  wire logic i_sda_oe,
   input  wire logic i_sda_out,
   output logic      o_scl,
   output logic      o_sda
);
   logic scl_reg = 1'b1;
   logic drv_reg = 1'b1;
   // The pull-up wins unless a party pulls the line low.
   assign o_sda = drv_reg & (i_sda_oe ? i_sda_out : 1'b1);
   // The bus clock idles high between frames.
   assign o_scl = scl_reg;
   task automatic step(input logic c, input logic d);
      scl_reg <= c;
      drv_reg <= d;
      repeat (4) @(posedge i_link_clk);
   endtask
   task automatic start();
      step(o_scl, 1'b1);
      step(1'b1, 1'b1);
      step(1'b1, 1'b0);
      step(1'b0, 1'b0);
   endtask
   task automatic stop();
      step(1'b0, 1'b0);
      step(1'b1, 1'b0);
      step(1'b1, 1'b1);
   endtask
   task automatic xfer(input logic [8:0] tx, output logic [8:0] rx);
      for (int i = 8; i >= 0; i--) begin
         step(1'b0, tx[i]);
         step(1'b1, tx[i]);
         rx[i] = o_sda;
         step(1'b1, tx[i]);
         step(1'b0, tx[i]);
      end
   endtask
endmodule // twi_host
`default_nettype wire

//--- tb/test_rtc_two_wire_target_port.sv
`timescale 1ns/10ps
`default_nettype none
module test_rtc_two_wire_target_port;
   logic        i_ref_clk, i_link_clk, i_reset, scl, sda, oe, sda_out, strobe, busy, nack;
   logic [5:0]  waddr;
   logic [7:0]  wdata;
   logic [8:0]  rx;
   logic [13:0] wq[$];
   int          n_mismatch, n_tests, n_nack;
   rtc_two_wire_target_port rtc_two_wire_target_port_inst (.i_ref_clk(i_ref_clk), .i_reset(i_reset),
      .i_link_clk(i_link_clk), .i_scl(scl), .i_sda_in(sda), .o_sda_out(sda_out), .o_sda_oe(oe),
      .o_wr_strobe(strobe), .o_wr_addr(waddr), .o_wr_data(wdata), .o_busy(busy), .o_nack_seen(nack));
   twi_host twi_host_inst (.i_link_clk(i_link_clk), .i_sda_oe(oe), .i_sda_out(sda_out), .o_scl(scl), .o_sda(sda));
   initial begin
      i_ref_clk = 1'b0;
      forever #25 i_ref_clk = ~i_ref_clk;
   end
   initial begin
      i_link_clk = 1'b0;
      #17;
      forever #62.5 i_link_clk = ~i_link_clk;
   end
   always @(posedge i_ref_clk) begin
      if (strobe === 1'b1) wq.push_back({waddr, wdata});
      if (nack === 1'b1) n_nack++;
   end
   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      n_tests++;
      if (got !== exp) begin
         n_mismatch++;
         $display("FAIL %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic wb(input logic [7:0] b, input logic ack);
      twi_host_inst.xfer({b, 1'b1}, rx);
      chk("ack", 16'(ack), 16'(rx[0]));
   endtask
   task automatic rb(input logic ack, input logic [7:0] exp);
      twi_host_inst.xfer({8'hFF, ack}, rx);
      chk("rdata", 16'(exp), 16'(rx[8:1]));
   endtask
   task automatic write_scen();
      twi_host_inst.start();
      wb(8'hD0, 1'b0);
      wb(8'h7F, 1'b0);
      chk("busy", 16'h0001, 16'(busy));
      wb(8'h11, 1'b0);
      wb(8'h22, 1'b0);
      wb(8'h33, 1'b0);
      twi_host_inst.stop();
      repeat (20) @(posedge i_ref_clk);
      chk("busy", 16'h0000, 16'(busy));
      chk("count", 16'h0003, 16'(wq.size()));
      chk("w0", 16'h3F11, 16'(wq[0]));
      chk("w1", 16'h0022, 16'(wq[1]));
      chk("w2", 16'h0133, 16'(wq[2]));
      wq.delete();
   endtask
   task automatic read_scen();
      twi_host_inst.start();
      wb(8'hD0, 1'b0);
      wb(8'h3F, 1'b0);
      twi_host_inst.start();
      wb(8'hD1, 1'b0);
      rb(1'b0, 8'h11);
      rb(1'b1, 8'h22);
      repeat (20) @(posedge i_link_clk);
      chk("nack", 16'h0001, 16'(n_nack));
      chk("sda", 16'h0001, 16'(sda));
      twi_host_inst.stop();
   endtask
   task automatic direct_scen();
      twi_host_inst.start();
      wb(8'hD1, 1'b0);
      rb(1'b1, 8'h33);
      twi_host_inst.stop();
   endtask
   task automatic stray_scen();
      twi_host_inst.start();
      wb(8'hA0, 1'b1);
      wb(8'h00, 1'b1);
      wb(8'h55, 1'b1);
      twi_host_inst.stop();
      repeat (20) @(posedge i_ref_clk);
      chk("stray", 16'h0000, 16'(wq.size()));
   endtask
   task automatic tally_and_finish();
      $display("mismatches %0d of %0d checks", n_mismatch, n_tests);
      if (n_mismatch == 0 && n_tests > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   initial begin
      #1000000;
      n_mismatch++;
      tally_and_finish();
   end
   initial begin
      i_reset <= 1'b1;
      repeat (10) @(posedge i_ref_clk);
      i_reset <= 1'b0;
      write_scen();
      read_scen();
      direct_scen();
      stray_scen();
      tally_and_finish();
   end
endmodule // test_rtc_two_wire_target_port
`default_nettype wire
